// ### spc_pkg.sv
// Constants, address map and state type for the shared port pin control block.
// Assumes a single 10 MHz core clock and a core that issues port-setup writes as bus writes.
`default_nettype none

package spc_pkg;

  // ----------------------------------------------------------------
  // Bus widths and clock
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 4;
  localparam int CLK_HZ = 10_000_000;

  // ----------------------------------------------------------------
  // Port-setup control words, addressed by control word number
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CW_ADC_CHAN = 5'h01;
  localparam logic [ADDR_W-1:0] CW_EDGE = 5'h03;
  localparam logic [ADDR_W-1:0] CW_DIR_K = 5'h04;
  localparam logic [ADDR_W-1:0] CW_DIR_L = 5'h05;
  localparam logic [ADDR_W-1:0] CW_DIR_M = 5'h06;
  localparam logic [ADDR_W-1:0] CW_ANA_H = 5'h07;
  localparam logic [ADDR_W-1:0] CW_ANA_I = 5'h08;

  // ----------------------------------------------------------------
  // Data, flag and command registers
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_OD_DATA = 5'h10;
  localparam logic [ADDR_W-1:0] A_K_DATA = 5'h11;
  localparam logic [ADDR_W-1:0] A_L_DATA = 5'h12;
  localparam logic [ADDR_W-1:0] A_M_DATA = 5'h13;
  localparam logic [ADDR_W-1:0] A_H_IN = 5'h14;
  localparam logic [ADDR_W-1:0] A_I_IN = 5'h15;
  localparam logic [ADDR_W-1:0] A_K_IN = 5'h16;
  localparam logic [ADDR_W-1:0] A_L_IN = 5'h17;
  localparam logic [ADDR_W-1:0] A_M_IN = 5'h18;
  localparam logic [ADDR_W-1:0] A_FLAGS = 5'h19;
  localparam logic [ADDR_W-1:0] A_CNT_CTRL = 5'h1a;
  localparam logic [ADDR_W-1:0] A_CLK_STOP = 5'h1b;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_HOLD_EN = 0;
  localparam int FLAG_IRQ0_EN = 1;
  localparam int FLAG_IRQ1_EN = 2;
  localparam int FLAG_GLOBAL_EN = 3;
  localparam int CC_START_BIT = 2;
  localparam int STAT_DONE = 0;
  localparam int STAT_STOP = 1;
  localparam int STAT_HOLD_PIN = 2;
  localparam int STAT_HOLD_ACT = 3;
  localparam int EDGE_IRQ0 = 0;
  localparam int EDGE_IRQ1 = 1;
  localparam int CHAN_W = 3;
  localparam int SYNC_W = 23;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_DIR = 4'h0;
  localparam logic [DATA_W-1:0] RST_ANA = 4'h0;
  localparam logic [DATA_W-1:0] RST_OD = 4'hf;
  localparam logic [DATA_W-1:0] RST_DATA = 4'h0;
  localparam logic [DATA_W-1:0] RST_FLAGS = 4'h0;
  localparam logic [DATA_W-1:0] ALL_ONES = 4'hf;
  localparam logic [DATA_W-1:0] ALL_ZERO = 4'h0;
  localparam logic [1:0] RST_EDGE = 2'h0;
  localparam logic [CHAN_W-1:0] RST_CHAN = 3'h0;

  // ----------------------------------------------------------------
  // Clock-stop state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_ST_RUN = 2'b01,
    SPC_ST_STOP = 2'b10
  } spc_state_type;

endpackage

`default_nettype wire

// ### spc_sync.sv
// Two-stage synchroniser for the pin inputs of the shared port block.
// Assumes the inputs are asynchronous levels; only the second stage may be read.
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_sync = sync_ff;

endmodule

`default_nettype wire

// ### spc_top.sv
// Pin control for the shared-function ports: clock stop, analog-shared inputs,
// open-drain outputs, interrupt-shared and plain bidirectional ports.
// Assumes one 10 MHz core clock, a core that writes control words and commands
// over the plain register port, and an external converter on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] Hold enabled and hold pin low block both oscillator inputs, float error output.
// [R2] Software sets hold enable, holds pin low, then issues clock stop.
// [R3] Clock-stop mode ends when the hold pin goes high.
// [R4] Control words 7 and 8 pick general or converter use per analog pin.
// [R5] Control word 1 selects the converter channel.
// [R6] Counter control with bit 2 set starts one conversion.
// [R7] Conversion-done flag sets when a conversion finishes.
// [R8] Reading a pin assigned to the converter returns low.
// [R9] Analog pins read low in clock stop; reset makes them general inputs.
// [R10] Open-drain port releases its transistors during clock stop.
// [R11] Reset leaves open-drain pins as outputs with transistors off.
// [R12] Interrupt-shared pins act as interrupt inputs once their enable is set.
// [R13] Software sets an interrupt pin to input before using it.
// [R14] An interrupt request also needs the global interrupt enable.
// [R15] Control word 3 picks edge: bit 1 second input, bit 0 first.
// [R16] Bidirectional pins choose direction per bit by port-setup writes.
// [R17] Bidirectional ports float and read low during clock stop.
// [R18] Reset makes every bidirectional pin an input.
// [R19] A port-setup write changes only the bits of its own control word.
module spc_top
  import spc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [spc_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [spc_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [spc_pkg::DATA_W-1:0] O_RDATA,
  input wire logic I_HOLD_B,
  input wire logic [3:0] I_ANALOG_SHARED_PORT_H,
  input wire logic [1:0] I_ANALOG_SHARED_PORT_I,
  input wire logic [3:0] I_OPEN_DRAIN_PORT,
  output logic [3:0] O_OPEN_DRAIN_PORT,
  output logic [3:0] O_OPEN_DRAIN_PORT_OE_B,
  input wire logic [3:0] I_IRQ_SHARED_PORT,
  output logic [3:0] O_IRQ_SHARED_PORT,
  output logic [3:0] O_IRQ_SHARED_PORT_OE_B,
  input wire logic [3:0] I_BIDIR_PORT_L,
  output logic [3:0] O_BIDIR_PORT_L,
  output logic [3:0] O_BIDIR_PORT_L_OE_B,
  input wire logic [3:0] I_BIDIR_PORT_M,
  output logic [3:0] O_BIDIR_PORT_M,
  output logic [3:0] O_BIDIR_PORT_M_OE_B,
  output logic O_OSC_INPUT_BLOCK,
  output logic O_PHASE_ERROR_OUTPUT_HIZ,
  output logic O_CLOCK_STOP,
  output logic [1:0] O_EXT_IRQ_REQ,
  output logic O_ADC_START,
  output logic [spc_pkg::CHAN_W-1:0] O_ADC_CHAN,
  output logic [5:0] O_ADC_PIN_SEL,
  input wire logic I_ADC_DONE
);

  import spc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keeps a pin's digital level only where its input path is open.
  function automatic logic [DATA_W-1:0] gate_in(input logic [DATA_W-1:0] lvl,
                                                input logic [DATA_W-1:0] open_mask);
    gate_in = lvl & open_mask;
  endfunction

  function automatic logic wr_at(input logic wr, input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
    wr_at = wr && (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic hold_s;
  logic [3:0] h_s;
  logic [1:0] i_s;
  logic [3:0] od_s;
  logic [3:0] k_s;
  logic [3:0] l_s;
  logic [3:0] m_s;

  spc_sync #(.WIDTH(SYNC_W)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_async({I_HOLD_B, I_ANALOG_SHARED_PORT_H, I_ANALOG_SHARED_PORT_I, I_OPEN_DRAIN_PORT,
              I_IRQ_SHARED_PORT, I_BIDIR_PORT_L, I_BIDIR_PORT_M}),
    .o_sync(pins_s)
  );

  assign {hold_s, h_s, i_s, od_s, k_s, l_s, m_s} = pins_s;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [CHAN_W-1:0] chan_ff, nxt_chan;
  logic [1:0] edge_ff, nxt_edge;
  logic [3:0] dir_k_ff, nxt_dir_k;
  logic [3:0] dir_l_ff, nxt_dir_l;
  logic [3:0] dir_m_ff, nxt_dir_m;
  logic [3:0] ana_h_ff, nxt_ana_h;
  logic [1:0] ana_i_ff, nxt_ana_i;
  logic [3:0] od_dat_ff, nxt_od_dat;
  logic [3:0] k_dat_ff, nxt_k_dat;
  logic [3:0] l_dat_ff, nxt_l_dat;
  logic [3:0] m_dat_ff, nxt_m_dat;
  logic [3:0] flags_ff, nxt_flags;

  // Each control word owns its own field; no write touches another one.
  always_comb begin
    nxt_chan = chan_ff;
    nxt_edge = edge_ff;
    nxt_dir_k = dir_k_ff;
    nxt_dir_l = dir_l_ff;
    nxt_dir_m = dir_m_ff;
    nxt_ana_h = ana_h_ff;
    nxt_ana_i = ana_i_ff;
    nxt_od_dat = od_dat_ff;
    nxt_k_dat = k_dat_ff;
    nxt_l_dat = l_dat_ff;
    nxt_m_dat = m_dat_ff;
    nxt_flags = flags_ff;
    if (I_WR) begin // see [R19]
      case (I_ADDR)
        CW_ADC_CHAN: nxt_chan = I_WDATA[CHAN_W-1:0]; // see [R5]
        CW_EDGE: nxt_edge = I_WDATA[1:0]; // see [R15]
        CW_DIR_K: nxt_dir_k = I_WDATA; // see [R16]
        CW_DIR_L: nxt_dir_l = I_WDATA; // see [R16]
        CW_DIR_M: nxt_dir_m = I_WDATA; // see [R16]
        CW_ANA_H: nxt_ana_h = I_WDATA; // see [R4]
        CW_ANA_I: nxt_ana_i = I_WDATA[1:0]; // see [R4]
        A_OD_DATA: nxt_od_dat = I_WDATA;
        A_K_DATA: nxt_k_dat = I_WDATA;
        A_L_DATA: nxt_l_dat = I_WDATA;
        A_M_DATA: nxt_m_dat = I_WDATA;
        A_FLAGS: nxt_flags = I_WDATA;
        default: nxt_flags = flags_ff;
      endcase
    end
  end

  // Reset values make every pin a plain input and release the open drains.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      chan_ff <= RST_CHAN;
      edge_ff <= RST_EDGE;
      dir_k_ff <= RST_DIR; // see [R18]
      dir_l_ff <= RST_DIR; // see [R18]
      dir_m_ff <= RST_DIR; // see [R18]
      ana_h_ff <= RST_ANA; // see [R9]
      ana_i_ff <= RST_ANA[1:0]; // see [R9]
      od_dat_ff <= RST_OD; // see [R11]
      k_dat_ff <= RST_DATA;
      l_dat_ff <= RST_DATA;
      m_dat_ff <= RST_DATA;
      flags_ff <= RST_FLAGS;
    end else begin
      chan_ff <= nxt_chan;
      edge_ff <= nxt_edge;
      dir_k_ff <= nxt_dir_k;
      dir_l_ff <= nxt_dir_l;
      dir_m_ff <= nxt_dir_m;
      ana_h_ff <= nxt_ana_h;
      ana_i_ff <= nxt_ana_i;
      od_dat_ff <= nxt_od_dat;
      k_dat_ff <= nxt_k_dat;
      l_dat_ff <= nxt_l_dat;
      m_dat_ff <= nxt_m_dat;
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------
  // Clock stop, conversion control and interrupt edges
  // ----------------------------------------------------------------
  spc_state_type state_ff, nxt_state;
  logic done_ff, nxt_done;
  logic [1:0] irq_prev_ff, nxt_irq_prev;
  logic hold_act;
  logic start_cmd;
  logic [1:0] irq_lvl;
  logic [1:0] irq_edge;
  logic [1:0] irq_en;
  logic in_stop;

  assign in_stop = (state_ff == SPC_ST_STOP);
  assign hold_act = flags_ff[FLAG_HOLD_EN] && !hold_s; // see [R1]
  assign start_cmd = wr_at(I_WR, I_ADDR, A_CNT_CTRL) && I_WDATA[CC_START_BIT]; // see [R6]
  assign irq_en = {flags_ff[FLAG_IRQ1_EN], flags_ff[FLAG_IRQ0_EN]};
  // The previous level keeps tracking the pin in clock stop, so leaving it makes no false edge.
  assign irq_lvl = k_s[1:0];

  // An edge select of 0 takes rising edges and 1 takes falling edges; none count in stop.
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      irq_edge[n] = !in_stop && (edge_ff[n] ? (irq_prev_ff[n] && !irq_lvl[n])
                                             : (!irq_prev_ff[n] && irq_lvl[n])); // see [R15]
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SPC_ST_RUN: begin
        // The stop command alone does nothing unless hold is already active.
        if (wr_at(I_WR, I_ADDR, A_CLK_STOP) && hold_act) begin // see [R2]
          nxt_state = SPC_ST_STOP;
        end
      end
      SPC_ST_STOP: begin
        if (hold_s) begin // see [R3]
          nxt_state = SPC_ST_RUN;
        end
      end
      default: nxt_state = SPC_ST_RUN;
    endcase
    // A finishing conversion beats the clear done by a new start.
    nxt_done = done_ff;
    if (start_cmd) begin
      nxt_done = 1'b0;
    end
    if (I_ADC_DONE) begin // see [R7]
      nxt_done = 1'b1;
    end
    nxt_irq_prev = irq_lvl;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      state_ff <= SPC_ST_RUN;
      done_ff <= 1'b0;
      irq_prev_ff <= 2'b00;
    end else begin
      state_ff <= nxt_state;
      done_ff <= nxt_done;
      irq_prev_ff <= nxt_irq_prev;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin and core outputs
  // ----------------------------------------------------------------
  logic [3:0] od_oe_b_ff, nxt_od_oe_b;
  logic [3:0] k_oe_b_ff, nxt_k_oe_b;
  logic [3:0] l_oe_b_ff, nxt_l_oe_b;
  logic [3:0] m_oe_b_ff, nxt_m_oe_b;
  logic [3:0] rdata_ff, nxt_rdata;
  logic osc_blk_ff, nxt_osc_blk;
  logic stop_ff, nxt_stop;
  logic [1:0] irq_req_ff, nxt_irq_req;
  logic start_ff, nxt_start;
  logic [5:0] pin_sel_ff, nxt_pin_sel;
  logic [3:0] in_open;

  assign in_open = in_stop ? ALL_ZERO : ALL_ONES;

  always_comb begin
    // Open drain pulls low only for a zero bit, and never while stopped.
    nxt_od_oe_b = in_stop ? ALL_ONES : od_dat_ff; // see [R10]
    // Output enables are low where a bit is an output; all float in stop.
    nxt_k_oe_b = in_stop ? ALL_ONES : ~dir_k_ff; // see [R17]
    nxt_l_oe_b = in_stop ? ALL_ONES : ~dir_l_ff; // see [R17]
    nxt_m_oe_b = in_stop ? ALL_ONES : ~dir_m_ff; // see [R17]
    nxt_osc_blk = hold_act; // see [R1]
    nxt_stop = in_stop;
    // Requests need the pin enable and the global enable together.
    nxt_irq_req = irq_edge & irq_en & {2{flags_ff[FLAG_GLOBAL_EN]}}; // see [R12] [R14]
    nxt_start = start_cmd; // see [R6]
    nxt_pin_sel = {ana_i_ff, ana_h_ff}; // see [R4]
    nxt_rdata = ALL_ZERO;
    if (I_RD) begin
      case (I_ADDR)
        CW_ADC_CHAN: nxt_rdata = {1'b0, chan_ff};
        CW_EDGE: nxt_rdata = {2'b00, edge_ff};
        CW_DIR_K: nxt_rdata = dir_k_ff;
        CW_DIR_L: nxt_rdata = dir_l_ff;
        CW_DIR_M: nxt_rdata = dir_m_ff;
        CW_ANA_H: nxt_rdata = ana_h_ff;
        CW_ANA_I: nxt_rdata = {2'b00, ana_i_ff};
        A_OD_DATA: nxt_rdata = od_s;
        A_K_DATA: nxt_rdata = k_dat_ff;
        A_L_DATA: nxt_rdata = l_dat_ff;
        A_M_DATA: nxt_rdata = m_dat_ff;
        A_H_IN: nxt_rdata = gate_in(h_s, in_open & ~ana_h_ff); // see [R8] [R9]
        A_I_IN: nxt_rdata = gate_in({2'b00, i_s}, in_open & {2'b00, ~ana_i_ff}); // see [R8]
        A_K_IN: nxt_rdata = gate_in(k_s, in_open); // see [R17]
        A_L_IN: nxt_rdata = gate_in(l_s, in_open); // see [R17]
        A_M_IN: nxt_rdata = gate_in(m_s, in_open); // see [R17]
        A_FLAGS: nxt_rdata = flags_ff;
        A_CNT_CTRL: nxt_rdata = {hold_act, hold_s, in_stop, done_ff};
        default: nxt_rdata = ALL_ZERO;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      od_oe_b_ff <= ALL_ONES; // see [R11]
      k_oe_b_ff <= ALL_ONES;
      l_oe_b_ff <= ALL_ONES;
      m_oe_b_ff <= ALL_ONES;
      rdata_ff <= ALL_ZERO;
      osc_blk_ff <= 1'b0;
      stop_ff <= 1'b0;
      irq_req_ff <= 2'b00;
      start_ff <= 1'b0;
      pin_sel_ff <= 6'h00;
    end else begin
      od_oe_b_ff <= nxt_od_oe_b;
      k_oe_b_ff <= nxt_k_oe_b;
      l_oe_b_ff <= nxt_l_oe_b;
      m_oe_b_ff <= nxt_m_oe_b;
      rdata_ff <= nxt_rdata;
      osc_blk_ff <= nxt_osc_blk;
      stop_ff <= nxt_stop;
      irq_req_ff <= nxt_irq_req;
      start_ff <= nxt_start;
      pin_sel_ff <= nxt_pin_sel;
    end
  end

  // Drive levels are the data latches, except the open-drain level, which is fixed low; the pads drive only where enabled.
  assign O_OPEN_DRAIN_PORT = ALL_ZERO;
  assign O_OPEN_DRAIN_PORT_OE_B = od_oe_b_ff;
  assign O_IRQ_SHARED_PORT = k_dat_ff;
  assign O_IRQ_SHARED_PORT_OE_B = k_oe_b_ff;
  assign O_BIDIR_PORT_L = l_dat_ff;
  assign O_BIDIR_PORT_L_OE_B = l_oe_b_ff;
  assign O_BIDIR_PORT_M = m_dat_ff;
  assign O_BIDIR_PORT_M_OE_B = m_oe_b_ff;
  assign O_OSC_INPUT_BLOCK = osc_blk_ff;
  assign O_PHASE_ERROR_OUTPUT_HIZ = osc_blk_ff;
  assign O_CLOCK_STOP = stop_ff;
  assign O_EXT_IRQ_REQ = irq_req_ff;
  assign O_ADC_START = start_ff;
  assign O_ADC_CHAN = chan_ff;
  assign O_ADC_PIN_SEL = pin_sel_ff;
  assign O_RDATA = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold_block;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      (flags_ff[FLAG_HOLD_EN] && !hold_s) |=> (O_OSC_INPUT_BLOCK && O_PHASE_ERROR_OUTPUT_HIZ);
  endproperty
  a_hold_block: assert property (p_hold_block) // see [R1]
    else $error("Hold active but oscillator inputs not blocked");

  property p_stop_exit;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      (in_stop && hold_s) |=> (state_ff == SPC_ST_RUN) ##1 !O_CLOCK_STOP;
  endproperty
  a_stop_exit: assert property (p_stop_exit) // see [R3]
    else $error("Clock stop not left after hold pin went high");

  property p_ana_read_low;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      (I_RD && I_ADDR == A_H_IN) |=> ((O_RDATA & $past(ana_h_ff)) == ALL_ZERO);
  endproperty
  a_ana_read_low: assert property (p_ana_read_low) // see [R8]
    else $error("Converter pin read back a high level");

  property p_od_release;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      in_stop |=> (O_OPEN_DRAIN_PORT_OE_B == ALL_ONES);
  endproperty
  a_od_release: assert property (p_od_release) // see [R10]
    else $error("Open drain driven during clock stop");

  property p_bidir_float;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      in_stop |=> (O_IRQ_SHARED_PORT_OE_B == ALL_ONES && O_BIDIR_PORT_L_OE_B == ALL_ONES
                   && O_BIDIR_PORT_M_OE_B == ALL_ONES);
  endproperty
  a_bidir_float: assert property (p_bidir_float) // see [R17]
    else $error("Bidirectional port driven during clock stop");

  property p_irq_gate;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      (O_EXT_IRQ_REQ != 2'b00) |-> $past(flags_ff[FLAG_GLOBAL_EN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // see [R14]
    else $error("Interrupt request without global enable");

  property p_adc_start;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      start_cmd |=> (O_ADC_START && !done_ff) or (O_ADC_START && $past(I_ADC_DONE));
  endproperty
  a_adc_start: assert property (p_adc_start) // see [R6]
    else $error("Start command did not start a conversion");

  property p_done_set;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      I_ADC_DONE |=> done_ff;
  endproperty
  a_done_set: assert property (p_done_set) // see [R7]
    else $error("Conversion done flag not set");

  property p_word_isolation;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      wr_at(I_WR, I_ADDR, CW_DIR_L) |=> (dir_k_ff == $past(dir_k_ff)
                                         && ana_h_ff == $past(ana_h_ff));
  endproperty
  a_word_isolation: assert property (p_word_isolation) // see [R19]
    else $error("Control word write disturbed another field");

  property p_chan_sel;
    @(posedge I_REF_CLK) disable iff (!I_RST_B)
      wr_at(I_WR, I_ADDR, CW_ADC_CHAN) |=> (O_ADC_CHAN == $past(I_WDATA[CHAN_W-1:0]));
  endproperty
  a_chan_sel: assert property (p_chan_sel) // see [R5]
    else $error("Converter channel not taken from control word 1");

endmodule

`default_nettype wire

// ### spc_board_model.sv
// Board-side model for the shared port block: pad resolution and a converter.
// Assumes pads without a driver follow the levels the bench applies to them.
`timescale 1ns/1ps
`default_nettype none

module spc_board_model #(
  parameter int CONV_CYC = 5
) (
  input wire logic i_clk,
  input wire logic i_adc_start,
  output logic o_adc_done,
  input wire logic [3:0] i_od_oe_b,
  output logic [3:0] o_od_pad,
  input wire logic [11:0] i_drv,
  input wire logic [11:0] i_oe_b,
  input wire logic [11:0] i_ext,
  output logic [11:0] o_pad
);
  logic [3:0] cnt = 4'h0;

  // Open-drain pads sit at the pull-up level unless their transistor is on.
  assign o_od_pad = i_od_oe_b;
  assign o_pad = (~i_oe_b & i_drv) | (i_oe_b & i_ext);

  // A conversion finishes a fixed time after its start pulse.
  always @(posedge i_clk) begin
    if (i_adc_start) begin
      cnt <= CONV_CYC[3:0];
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
    o_adc_done <= (cnt == 4'h1);
  end
endmodule

`default_nettype wire

// ### spc_top_bench.sv
// Self-checking bench for the shared port pin control block.
// Assumes the board model resolves pads and answers conversion starts.
`timescale 1ns/1ps
`default_nettype none

module spc_top_bench;
  import spc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [3:0] wdata = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold_b = 1'b1;
  logic [3:0] ext_h = 4'hf;
  logic [1:0] ext_i = 2'h3;
  logic [11:0] ext = 12'h050;
  logic [3:0] rdata, od_oe, od_pad, od_drv;
  wire logic [11:0] drv, oe_b, pad;
  logic osc_blk, hiz, cstop, adc_start, adc_done;
  logic [1:0] irq;
  logic [2:0] chan;
  logic [5:0] pin_sel;
  logic [3:0] v;
  int n_errors = 0;
  int total_checks = 0;
  int n_irq0 = 0;
  int n_irq1 = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  spc_top dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_HOLD_B(hold_b), .I_ANALOG_SHARED_PORT_H(ext_h),
    .I_ANALOG_SHARED_PORT_I(ext_i), .I_OPEN_DRAIN_PORT(od_pad), .O_OPEN_DRAIN_PORT(od_drv),
    .O_OPEN_DRAIN_PORT_OE_B(od_oe), .I_IRQ_SHARED_PORT(pad[3:0]), .O_IRQ_SHARED_PORT(drv[3:0]),
    .O_IRQ_SHARED_PORT_OE_B(oe_b[3:0]), .I_BIDIR_PORT_L(pad[7:4]), .O_BIDIR_PORT_L(drv[7:4]),
    .O_BIDIR_PORT_L_OE_B(oe_b[7:4]), .I_BIDIR_PORT_M(pad[11:8]), .O_BIDIR_PORT_M(drv[11:8]),
    .O_BIDIR_PORT_M_OE_B(oe_b[11:8]), .O_OSC_INPUT_BLOCK(osc_blk),
    .O_PHASE_ERROR_OUTPUT_HIZ(hiz), .O_CLOCK_STOP(cstop), .O_EXT_IRQ_REQ(irq),
    .O_ADC_START(adc_start), .O_ADC_CHAN(chan), .O_ADC_PIN_SEL(pin_sel), .I_ADC_DONE(adc_done));

  spc_board_model board (.i_clk(clk), .i_adc_start(adc_start), .o_adc_done(adc_done),
    .i_od_oe_b(od_oe), .o_od_pad(od_pad), .i_drv(drv), .i_oe_b(oe_b), .i_ext(ext), .o_pad(pad));

  always @(posedge clk) begin
    if (irq[0] === 1'b1) n_irq0 <= n_irq0 + 1;
    if (irq[1] === 1'b1) n_irq1 <= n_irq1 + 1;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Registered outputs are looked at mid-cycle, never in the edge that launches them.
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [3:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic pulse_k(input int b);
    @(posedge clk);
    ext[b] <= 1'b1;
    cyc(8);
    ext[b] <= 1'b0;
    cyc(8);
  endtask

  task automatic end_sim;
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(3000 * 100);
    n_errors++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    rst_b <= 1'b1;
    look(4);
    chk("oe after reset", oe_b, 12'hfff);
    chk("od oe after reset", od_oe, 4'hf);
    rd_reg(A_OD_DATA, v); chk("od pad", v, 4'hf);
    rd_reg(A_H_IN, v); chk("h in at reset", v, 4'hf);
    wr_reg(CW_DIR_L, 4'h3);
    wr_reg(CW_DIR_M, 4'ha);
    wr_reg(A_L_DATA, 4'hf);
    wr_reg(A_M_DATA, 4'h9);
    look(3);
    chk("l oe", oe_b[7:4], 4'hc);
    chk("m oe", oe_b[11:8], 4'h5);
    rd_reg(CW_DIR_L, v); chk("dir l kept", v, 4'h3);
    rd_reg(A_L_IN, v); chk("l in", v, 4'h7);
    rd_reg(A_M_IN, v); chk("m in", v, 4'h8);
    wr_reg(A_OD_DATA, 4'h5);
    look(4);
    chk("od oe", od_oe, 4'h5);
    chk("od drive level", od_drv, 4'h0);
    rd_reg(A_OD_DATA, v); chk("od readback", v, 4'h5);
    wr_reg(CW_ANA_H, 4'h5);
    wr_reg(CW_ANA_I, 4'h2);
    rd_reg(A_H_IN, v); chk("h in", v, 4'ha);
    rd_reg(A_I_IN, v); chk("i in", v, 4'h1);
    rd_reg(CW_ANA_H, v); chk("ana h kept", v, 4'h5);
    chk("pin sel", pin_sel, 6'h25);
    wr_reg(CW_ADC_CHAN, 4'h5);
    wr_reg(A_CNT_CTRL, 4'h4);
    @(negedge clk);
    chk("adc start", adc_start, 1'b1);
    chk("adc chan", chan, 3'h5);
    @(negedge clk);
    chk("adc start pulse", adc_start, 1'b0);
    cyc(10);
    rd_reg(A_CNT_CTRL, v); chk("done flag", v[STAT_DONE], 1'b1);
    wr_reg(CW_DIR_K, 4'h0);
    wr_reg(CW_EDGE, 4'h0);
    wr_reg(A_FLAGS, 4'h2);
    pulse_k(0);
    chk("irq0 no global", n_irq0[15:0], 16'h0000);
    wr_reg(A_FLAGS, 4'ha);
    pulse_k(0);
    chk("irq0 rising", n_irq0[15:0], 16'h0001);
    wr_reg(CW_EDGE, 4'h1);
    pulse_k(0);
    chk("irq0 falling", n_irq0[15:0], 16'h0002);
    wr_reg(CW_EDGE, 4'h2);
    wr_reg(A_FLAGS, 4'hc);
    pulse_k(1);
    pulse_k(0);
    chk("irq1 count", n_irq1[15:0], 16'h0001);
    chk("irq0 disabled", n_irq0[15:0], 16'h0002);
    hold_b <= 1'b0;
    cyc(4);
    wr_reg(A_CLK_STOP, 4'h0);
    look(4);
    chk("stop refused", {cstop, osc_blk}, 2'h0);
    wr_reg(A_FLAGS, 4'h1);
    look(4);
    chk("osc block", {osc_blk, hiz}, 2'h3);
    wr_reg(A_CLK_STOP, 4'h0);
    look(4);
    chk("clock stop", cstop, 1'b1);
    chk("oe in stop", {od_oe, oe_b}, 16'hffff);
    rd_reg(A_H_IN, v); chk("h in stop", v, 4'h0);
    rd_reg(A_L_IN, v); chk("l in stop", v, 4'h0);
    @(posedge clk);
    hold_b <= 1'b1;
    look(6);
    chk("stop exit", cstop, 1'b0);
    chk("hold released", {osc_blk, hiz}, 2'h0);
    chk("l oe after stop", oe_b[7:4], 4'hc);
    end_sim;
  end
endmodule

`default_nettype wire
